/* logic/dac_port_pkg.sv */
// Shared constants for the serial load port of the 12-bit DAC
`default_nettype none

package dac_port_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS   = 16;
  localparam int DATA_BITS    = 12;
  localparam int CMD_READ_BIT = 15;
  localparam int ADDR_MSB     = 14;
  localparam int ADDR_LSB     = 12;

  // Register addresses inside a frame
  localparam logic [2:0] ADDR_INPUT = 3'h1;
  localparam logic [2:0] ADDR_DAC   = 3'h2;
  localparam logic [2:0] ADDR_CTRL  = 3'h3;

  // Reset values
  localparam logic [11:0] ZERO_CODE  = 12'h000;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ         = 25_000_000;
  localparam longint SCLK_PERIOD_NS = 320;
  localparam longint POR_TIME_US    = 50;
  localparam longint LOAD_LOW_NS    = 20;
  // Half period of the generated shift clock, rounded down
  localparam int SCLK_HALF_CYC = int'((SCLK_PERIOD_NS * CLK_HZ) / 2_000_000_000);
  // Longest wait: rounded down
  localparam int POR_CYC = int'(POR_TIME_US * CLK_HZ / 1_000_000);
  // Least pulse width: rounded up
  localparam int LOAD_LOW_CYC = int'((LOAD_LOW_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  // Idle time between frames
  localparam int FRAME_GAP_CYC = 2 * SCLK_HALF_CYC;

endpackage

`default_nettype wire

/* logic/dac_link_if.sv */
// Pin bundle between the host end and the DAC serial port end
`default_nettype none

interface dac_link_if;
  logic frame_sel_n;
  logic shift_clk;
  logic serial_in_line;
  logic serial_out_line;
  logic load_output_n;
  logic async_zero_n;

  modport dev (
    input  frame_sel_n,
    input  shift_clk,
    input  serial_in_line,
    input  load_output_n,
    input  async_zero_n,
    output serial_out_line
  );

  modport host (
    output frame_sel_n,
    output shift_clk,
    output serial_in_line,
    output load_output_n,
    output async_zero_n,
    input  serial_out_line
  );
endinterface

`default_nettype wire

/* logic/dac_port_dev.sv */
// Device end: serial load port with input, DAC and control registers
`default_nettype none

module dac_port_dev (
  input  wire logic                                clk_in,
  input  wire logic                                nrst_in,
  dac_link_if.dev                                  link,
  output logic [dac_port_pkg::DATA_BITS-1:0]       dac_code_out,
  output logic [dac_port_pkg::DATA_BITS-1:0]       input_code_out,
  output logic [dac_port_pkg::DATA_BITS-1:0]       ctrl_word_out,
  output logic                                     write_done_out
);
  import dac_port_pkg::*;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_SHIFT,
    FR_DONE
  } frame_e;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Bit 0 frame select, 1 shift clock, 2 serial in, 3 load strobe
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;

  // Two flops, then an edge history flop; reset to idle pin levels
  // so that no false edge is seen just after reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= 4'h9;
      sync_q <= 4'h9;
      prev_q <= 4'h9;
    end else begin
      meta_q <= {link.load_output_n, link.serial_in_line,
                 link.shift_clk, link.frame_sel_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge events seen on the synchronised copies
  logic fs_fall;
  logic fs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_bit;
  logic load_fall;
  logic load_low;

  assign fs_fall   = ~sync_q[0] & prev_q[0];
  assign fs_rise   = sync_q[0] & ~prev_q[0];
  assign sclk_rise = sync_q[1] & ~prev_q[1];
  assign sclk_fall = ~sync_q[1] & prev_q[1];
  assign sdi_bit   = sync_q[2];
  assign load_fall = ~sync_q[3] & prev_q[3];
  assign load_low  = ~sync_q[3];

  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  frame_e                  state_q;
  frame_e                  state_d;
  logic [4:0]              cnt_q;
  logic [4:0]              cnt_d;
  logic [FRAME_BITS-1:0]   shift_q;
  logic [FRAME_BITS-1:0]   shift_d;
  logic [FRAME_BITS-1:0]   out_q;
  logic [FRAME_BITS-1:0]   out_d;
  logic [FRAME_BITS-1:0]   rb_q;
  logic [FRAME_BITS-1:0]   rb_d;
  logic                    sdo_q;
  logic                    sdo_d;
  logic                    done_q;
  logic                    done_d;
  logic                    commit;

  // Register contents as seen by the readback mux
  logic [DATA_BITS-1:0]    input_q;
  logic [DATA_BITS-1:0]    dac_q;
  logic [DATA_BITS-1:0]    ctrl_q;
  logic [DATA_BITS-1:0]    rd_val;
  logic [2:0]              addr;

  assign addr = shift_q[ADDR_MSB:ADDR_LSB];

  // Readback selection
  always_comb begin
    case (addr)
      ADDR_INPUT: rd_val = input_q;
      ADDR_DAC:   rd_val = dac_q;
      ADDR_CTRL:  rd_val = ctrl_q;
      default:    rd_val = ZERO_CODE;
    endcase
  end

  // Next state of the frame engine
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    out_d   = out_q;
    rb_d    = rb_q;
    sdo_d   = sdo_q;
    done_d  = 1'b0;
    commit  = 1'b0;
    if (fs_fall) begin
      // Fresh frame whatever came before
      state_d = FR_SHIFT;
      cnt_d   = 5'd0;
      shift_d = '0;
      out_d   = rb_q;
    end else begin
      case (state_q)
        FR_IDLE: begin
          state_d = FR_IDLE;
        end
        FR_SHIFT: begin
          if (fs_rise) begin
            // Partial frame is dropped, nothing committed
            state_d = FR_IDLE;
          end else begin
            if (sclk_rise && cnt_q < 5'(FRAME_BITS)) begin
              shift_d = {shift_q[FRAME_BITS-2:0], sdi_bit};
              cnt_d   = cnt_q + 5'd1;
              sdo_d   = out_q[FRAME_BITS-1];
              out_d   = {out_q[FRAME_BITS-2:0], 1'b0};
            end
            if (sclk_fall && cnt_q == 5'(FRAME_BITS)) begin
              commit  = 1'b1;
              done_d  = 1'b1;
              state_d = FR_DONE;
              if (shift_q[CMD_READ_BIT]) begin
                // Read word goes out during the next frame
                rb_d = {1'b0, addr, rd_val};
              end
            end
          end
        end
        FR_DONE: begin
          // Extra clocks after the commit are ignored
          if (fs_rise) begin
            state_d = FR_IDLE;
          end
        end
        default: begin
          state_d = FR_IDLE;
        end
      endcase
    end
  end

  // Frame engine registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= FR_IDLE;
      cnt_q   <= 5'd0;
      shift_q <= '0;
      out_q   <= '0;
      rb_q    <= '0;
      sdo_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      out_q   <= out_d;
      rb_q    <= rb_d;
      sdo_q   <= sdo_d;
      done_q  <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------
  logic                 wr_input;
  logic                 wr_ctrl;
  logic [DATA_BITS-1:0] input_d;
  logic [DATA_BITS-1:0] dac_d;
  logic [DATA_BITS-1:0] ctrl_d;
  logic                 zero_rst_n;

  assign wr_input = commit & ~shift_q[CMD_READ_BIT] & (addr == ADDR_INPUT);
  assign wr_ctrl  = commit & ~shift_q[CMD_READ_BIT] & (addr == ADDR_CTRL);

  // Clear pin doubles as asynchronous reset of the code registers;
  // the host drives it from a flop, so it cannot glitch
  assign zero_rst_n = nrst_in & link.async_zero_n;

  // Load behaviour: pulse copies, held low follows every input register write
  always_comb begin
    input_d = input_q;
    dac_d   = dac_q;
    ctrl_d  = ctrl_q;
    if (load_fall) begin
      dac_d = input_q;
    end
    if (wr_input) begin
      input_d = shift_q[DATA_BITS-1:0];
      if (load_low) begin
        dac_d = shift_q[DATA_BITS-1:0];
      end
    end
    if (wr_ctrl) begin
      ctrl_d = shift_q[DATA_BITS-1:0];
    end
  end

  // Code registers, held at zero scale while clear is low, so load
  // strobes in that time cannot move anything
  always_ff @(posedge clk_in or negedge zero_rst_n) begin
    if (!zero_rst_n) begin
      input_q <= ZERO_CODE;
      dac_q   <= ZERO_CODE;
    end else begin
      input_q <= input_d;
      dac_q   <= dac_d;
    end
  end

  // Control word survives a clear, only power reset zeroes it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------
  assign link.serial_out_line = sdo_q;
  assign dac_code_out         = dac_q;
  assign input_code_out       = input_q;
  assign ctrl_word_out        = ctrl_q;
  assign write_done_out       = done_q;

endmodule // dac_port_dev

`default_nettype wire

/* logic/dac_port_host.sv */
// Host end: frames commands onto the serial load port, drives strobes
`default_nettype none

module dac_port_host (
  input  wire logic                            clk_in,
  input  wire logic                            nrst_in,
  dac_link_if.host                             link,
  input  wire logic                            start_in,
  input  wire logic [dac_port_pkg::FRAME_BITS-1:0] cmd_in,
  input  wire logic                            load_pulse_in,
  input  wire logic                            load_hold_in,
  input  wire logic                            zero_in,
  output logic                                 ready_out,
  output logic                                 busy_out,
  output logic [dac_port_pkg::FRAME_BITS-1:0]  rdata_out,
  output logic                                 done_out
);
  import dac_port_pkg::*;

  typedef enum logic [2:0] {
    H_POR,
    H_IDLE,
    H_LEAD,
    H_HIGH,
    H_LOW,
    H_GAP
  } host_e;

  // ---------------------------------------------------------------
  // Serial return synchroniser
  // ---------------------------------------------------------------
  logic sdo_meta_q;
  logic sdo_sync_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sdo_meta_q <= 1'b0;
      sdo_sync_q <= 1'b0;
    end else begin
      sdo_meta_q <= link.serial_out_line;
      sdo_sync_q <= sdo_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  host_e                 st_q, st_d;
  logic [10:0]           cnt_q, cnt_d;
  logic [4:0]            bit_q, bit_d;
  logic [FRAME_BITS-1:0] tx_q, tx_d;
  logic [FRAME_BITS-1:0] rx_q, rx_d;
  logic [FRAME_BITS-1:0] rdata_q, rdata_d;
  logic                  fs_q, fs_d;
  logic                  sclk_q, sclk_d;
  logic                  sdi_q, sdi_d;
  logic                  done_q, done_d;
  logic                  busy_q;

  // Return bits are taken late in the low phase: the device answer
  // needs several cycles through both synchronisers
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    rdata_d = rdata_q;
    fs_d    = fs_q;
    sclk_d  = sclk_q;
    sdi_d   = sdi_q;
    done_d  = 1'b0;
    case (st_q)
      H_POR: begin
        // No traffic until the power-on wait has run out
        if (cnt_q == 11'd0) begin
          st_d = H_IDLE;
        end else begin
          cnt_d = cnt_q - 11'd1;
        end
      end
      H_IDLE: begin
        if (start_in) begin
          fs_d  = 1'b0;
          tx_d  = {cmd_in[FRAME_BITS-2:0], 1'b0};
          sdi_d = cmd_in[FRAME_BITS-1];
          bit_d = 5'd0;
          cnt_d = 11'(SCLK_HALF_CYC - 1);
          st_d  = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (cnt_q != 11'd0) begin
          cnt_d = cnt_q - 11'd1;
        end else begin
          if (st_q == H_LOW) begin
            rx_d = {rx_q[FRAME_BITS-2:0], sdo_sync_q};
          end
          if (bit_q == 5'(FRAME_BITS)) begin
            // Select rises only after the sixteenth falling edge
            fs_d    = 1'b1;
            rdata_d = {rx_q[FRAME_BITS-2:0], sdo_sync_q};
            done_d  = 1'b1;
            cnt_d   = 11'(FRAME_GAP_CYC - 1);
            st_d    = H_GAP;
          end else begin
            sclk_d = 1'b1;
            bit_d  = bit_q + 5'd1;
            cnt_d  = 11'(SCLK_HALF_CYC - 1);
            st_d   = H_HIGH;
          end
        end
      end
      H_HIGH: begin
        if (cnt_q != 11'd0) begin
          cnt_d = cnt_q - 11'd1;
        end else begin
          // Data moves on the falling edge, stable at the next rise
          sclk_d = 1'b0;
          sdi_d  = tx_q[FRAME_BITS-1];
          tx_d   = {tx_q[FRAME_BITS-2:0], 1'b0};
          cnt_d  = 11'(SCLK_HALF_CYC - 1);
          st_d   = H_LOW;
        end
      end
      H_GAP: begin
        if (cnt_q != 11'd0) begin
          cnt_d = cnt_q - 11'd1;
        end else begin
          st_d = H_IDLE;
        end
      end
      default: begin
        st_d = H_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q    <= H_POR;
      cnt_q   <= 11'(POR_CYC);
      bit_q   <= 5'd0;
      tx_q    <= '0;
      rx_q    <= '0;
      rdata_q <= '0;
      fs_q    <= 1'b1;
      sclk_q  <= 1'b0;
      sdi_q   <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      tx_q    <= tx_d;
      rx_q    <= rx_d;
      rdata_q <= rdata_d;
      fs_q    <= fs_d;
      sclk_q  <= sclk_d;
      sdi_q   <= sdi_d;
      done_q  <= done_d;
      busy_q  <= (st_d != H_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Load and clear strobes
  // ---------------------------------------------------------------
  logic [3:0] ld_cnt_q, ld_cnt_d;
  logic       load_n_q, load_n_d;
  logic       zero_n_q;

  // A pulse request restarts the low time; hold keeps it low
  always_comb begin
    ld_cnt_d = (ld_cnt_q != 4'd0) ? ld_cnt_q - 4'd1 : 4'd0;
    if (load_pulse_in) begin
      ld_cnt_d = 4'(LOAD_LOW_CYC);
    end
    load_n_d = ~(load_hold_in | (ld_cnt_d != 4'd0));
  end

  // Strobes leave from flops so the device never sees a glitch
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ld_cnt_q <= 4'd0;
      load_n_q <= 1'b1;
      zero_n_q <= 1'b1;
    end else begin
      ld_cnt_q <= ld_cnt_d;
      load_n_q <= load_n_d;
      zero_n_q <= ~zero_in;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.frame_sel_n    = fs_q;
  assign link.shift_clk      = sclk_q;
  assign link.serial_in_line = sdi_q;
  assign link.load_output_n  = load_n_q;
  assign link.async_zero_n   = zero_n_q;
  assign ready_out           = ~busy_q;
  assign busy_out            = busy_q;
  assign rdata_out           = rdata_q;
  assign done_out            = done_q;

endmodule // dac_port_host

`default_nettype wire

/* verification/dac_link_chk.sv */
// Concurrent checks on the host-to-device serial link
`default_nettype none

module dac_link_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic load_output_n,
  input wire logic async_zero_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] falls_q;
  logic [4:0] falls_d;
  logic       sclk_q;
  logic       fsel_q;

  // ----------------------------------------
  // Helper: shift clock falls in this frame
  // ----------------------------------------
  // Restart on frame open, so an old frame never leaks in
  always_comb begin
    falls_d = falls_q;
    if (fsel_q && !frame_sel_n) begin
      falls_d = 5'h00;
    end else if (sclk_q && !shift_clk) begin
      falls_d = falls_q + 5'h01;
    end
  end

  // Registers for the counter and edge history
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      falls_q <= 5'h00;
      sclk_q  <= 1'b0;
      fsel_q  <= 1'b1;
    end else begin
      falls_q <= falls_d;
      sclk_q  <= shift_clk;
      fsel_q  <= frame_sel_n;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_low_phase;
    !shift_clk [*4] ##1 shift_clk;
  endsequence
  sequence s_high_phase;
    shift_clk [*4] ##1 !shift_clk;
  endsequence

  a_idle_clk_low: assert property (frame_sel_n |-> !shift_clk)
    else $error("shift clock high outside a frame");
  a_open_then_rise: assert property ($fell(frame_sel_n) |-> s_low_phase)
    else $error("first rise not four cycles after frame open");
  a_rise_in_frame: assert property ($rose(shift_clk) |-> !frame_sel_n)
    else $error("shift clock rose with frame select high");
  a_high_phase: assert property ($rose(shift_clk) |-> s_high_phase)
    else $error("shift clock high phase not four cycles");
  a_data_steady: assert property (shift_clk |-> $stable(serial_in_line))
    else $error("serial input moved while clock high");
  a_frame_len: assert property ($rose(frame_sel_n) |-> falls_q == 5'h10)
    else $error("frame did not carry sixteen falls");
  a_close_after: assert property ($fell(shift_clk) && falls_q == 5'h0f
      |-> !frame_sel_n [*4] ##1 frame_sel_n)
    else $error("frame not closed after sixteenth fall");
  // Device answers a rise three sampled cycles later, still in the high phase
  a_out_edge: assert property ($changed(serial_out_line) |-> shift_clk
      && $past(shift_clk, 3) && !$past(shift_clk, 4))
    else $error("serial output moved away from its edge");
  a_gap_min: assert property ($rose(frame_sel_n) |-> frame_sel_n [*8])
    else $error("frame gap shorter than eight cycles");

  c_clear: cover property ($fell(async_zero_n));
  c_load: cover property ($fell(load_output_n));
endmodule // dac_link_chk

`default_nettype wire

/* verification/hv_dac_serial_load_port_tb.sv */
// Testbench joining host and device ends, plus a hand-driven device
`default_nettype none

module hv_dac_serial_load_port_tb;
  import dac_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] cmd;
    logic        hold;
    logic [11:0] inp;
    logic [11:0] dac;
    logic [11:0] ctrl;
    logic        rchk;
    logic [15:0] rd;
  } row_s;

  logic        clk_in;
  logic        nrst_in;
  logic        start_in;
  logic [15:0] cmd_in;
  logic        load_pulse_in;
  logic        load_hold_in;
  logic        zero_in;
  logic        ready_out;
  logic        busy_out;
  logic [15:0] rdata_out;
  logic        done_out;
  logic [11:0] dac_code;
  logic [11:0] input_code;
  logic [11:0] ctrl_word;
  logic [11:0] input_code_b;
  logic        write_done;
  int          err_total;
  int          compares;
  int          cycles;
  row_s        rows [7];

  dac_link_if link ();
  dac_link_if link_b ();

  dac_port_host i_dac_port_host (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .start_in(start_in), .cmd_in(cmd_in), .load_pulse_in(load_pulse_in),
    .load_hold_in(load_hold_in), .zero_in(zero_in), .ready_out(ready_out),
    .busy_out(busy_out), .rdata_out(rdata_out), .done_out(done_out));
  dac_port_dev i_dac_port_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(link),
    .dac_code_out(dac_code), .input_code_out(input_code),
    .ctrl_word_out(ctrl_word), .write_done_out(write_done));
  // Second device end, driven by hand to break the frame rules
  dac_port_dev i_dac_port_dev_b (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_b),
    .dac_code_out(), .input_code_out(input_code_b),
    .ctrl_word_out(), .write_done_out());
  dac_link_chk i_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .frame_sel_n(link.frame_sel_n), .shift_clk(link.shift_clk),
    .serial_in_line(link.serial_in_line), .serial_out_line(link.serial_out_line),
    .load_output_n(link.load_output_n), .async_zero_n(link.async_zero_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hands one command to the host end and waits for its frame to close
  task automatic send(input logic [15:0] c, input logic h);
    int   k;
    logic wd;
    k = 0;
    wd = 1'b0;
    while (ready_out !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    check("host ready", 16'(ready_out), 16'h0001);
    @(posedge clk_in);
    cmd_in <= c;
    load_hold_in <= h;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 300) begin
      @(negedge clk_in);
      wd = wd | (write_done === 1'b1);
      k++;
    end
    check("host frame done", 16'(done_out), 16'h0001);
    check("device commit", 16'(wd), 16'h0001);
    repeat (3) @(negedge clk_in);
  endtask

  // Hand-made frame of n bits on the second link; n below 16 aborts
  task automatic bframe(input logic [15:0] c, input int n);
    @(posedge clk_in);
    link_b.frame_sel_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      link_b.serial_in_line <= c[i];
      repeat (4) @(posedge clk_in);
      link_b.shift_clk <= 1'b1;
      repeat (4) @(posedge clk_in);
      link_b.shift_clk <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    link_b.frame_sel_n <= 1'b1;
    link_b.serial_in_line <= ~link_b.serial_in_line;
    repeat (10) @(negedge clk_in);
  endtask

  // ----------------------------------------
  // Clock, time limit and stimulus
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Whole run needs about 2800 cycles; near three times that means a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    err_total = 0;
    compares = 0;
    cycles = 0;
    nrst_in = 1'b0;
    start_in = 1'b0;
    cmd_in = 16'h0000;
    load_pulse_in = 1'b0;
    load_hold_in = 1'b0;
    zero_in = 1'b0;
    link_b.frame_sel_n = 1'b1;
    link_b.shift_clk = 1'b0;
    link_b.serial_in_line = 1'b0;
    link_b.load_output_n = 1'b1;
    link_b.async_zero_n = 1'b1;
    rows[0] = {16'h1a5c, 1'b0, 12'ha5c, 12'h000, 12'h000, 1'b1, 16'h0000};
    rows[1] = {16'h3123, 1'b0, 12'ha5c, 12'h000, 12'h123, 1'b0, 16'h0000};
    rows[2] = {16'h2555, 1'b0, 12'ha5c, 12'h000, 12'h123, 1'b0, 16'h0000};
    rows[3] = {16'h9000, 1'b0, 12'ha5c, 12'h000, 12'h123, 1'b0, 16'h0000};
    rows[4] = {16'hb000, 1'b0, 12'ha5c, 12'h000, 12'h123, 1'b1, 16'h1a5c};
    rows[5] = {16'ha000, 1'b0, 12'ha5c, 12'h000, 12'h123, 1'b1, 16'h3123};
    rows[6] = {16'h1fff, 1'b1, 12'hfff, 12'hfff, 12'h123, 1'b1, 16'h2000};
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    check("dac after reset", 16'(dac_code), 16'h0000);
    check("frame select idle", 16'(link.frame_sel_n), 16'h0001);
    repeat (POR_CYC - 50) @(negedge clk_in);
    check("busy in power-on wait", 16'(busy_out), 16'h0001);
    // Ordinary traffic from the table
    foreach (rows[i]) begin
      send(rows[i].cmd, rows[i].hold);
      check("input register", 16'(input_code), 16'(rows[i].inp));
      check("dac register", 16'(dac_code), 16'(rows[i].dac));
      check("control word", 16'(ctrl_word), 16'(rows[i].ctrl));
      if (rows[i].rchk) begin
        check("readback", rdata_out, rows[i].rd);
      end
    end
    // Clear zeroes both registers; load pulses meanwhile do nothing
    @(posedge clk_in);
    zero_in <= 1'b1;
    load_hold_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    check("input under clear", 16'(input_code), 16'h0000);
    check("dac under clear", 16'(dac_code), 16'h0000);
    @(posedge clk_in);
    load_pulse_in <= 1'b1;
    @(posedge clk_in);
    load_pulse_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    zero_in <= 1'b0;
    repeat (8) @(negedge clk_in);
    check("dac after ignored load", 16'(dac_code), 16'h0000);
    send(16'h1333, 1'b0);
    check("dac waits for load", 16'(dac_code), 16'h0000);
    @(posedge clk_in);
    load_pulse_in <= 1'b1;
    @(posedge clk_in);
    load_pulse_in <= 1'b0;
    repeat (8) @(negedge clk_in);
    check("dac after load pulse", 16'(dac_code), 16'h0333);
    // Aborted frame, then a whole one, on the hand-driven link
    bframe(16'h1abc, 15);
    check("aborted write", 16'(input_code_b), 16'h0000);
    bframe(16'h1abc, 16);
    check("write after abort", 16'(input_code_b), 16'h0abc);
    give_verdict();
  end
endmodule // hv_dac_serial_load_port_tb

`default_nettype wire
